// ---- dv/pixel_sink.sv ----
// Behavioural receiver: latches the pixel port and sources the external sync
`default_nettype none
module pixel_sink (
  input  wire logic       pixel_data_strobe,
  input  wire logic [7:0] digital_pixel_port,
  input  wire logic       sync_req,
  output var  logic       ext_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got_q[$];  // Captured bytes in arrival order
  // Capture on the strobe's rise, half a period after the byte settled
  always @(posedge pixel_data_strobe)
  begin
    got_q.push_back(digital_pixel_port);
  end
  // Sync line follows the bench's request
  always_comb
  begin
    ext_sync = sync_req;
  end
endmodule // pixel_sink
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the video sync and pixel output block
`include "video_sync_defines.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        video_clk = 1'b0;
  logic        sync_req = 1'b0;
  logic [7:0]  palette_data = 8'h00;
  logic [31:0] prdata, rd;
  logic [7:0]  digital_pixel_port;
  logic        pready, pslverr, pixel_data_strobe, hsync_out, vsync_out, ext_sync, er;
  int          err_count = 0;
  int          cmp_count = 0;
  int          sr_cnt = 0;  // Strobe rises
  int          vr_cnt = 0;  // Link clock rises
  int          w, k;
  logic [31:0] rst_t[4] = '{32'h0, 32'h0, 32'h0030_0320, 32'h0002_020D};
  logic [31:0] ext_t[5] = '{32'h0, 32'h0, 32'h0001_0000, 32'h0002_0000, 32'h0004_0000};
  int          sel_t[5] = '{0, 1, 0, 0, 1};
  int          exp_t[5] = '{32, 128, 96, 96, 384};  // 8 bus cycles per pixel
  always #10 pclk = ~pclk;
  // Link clock, offset so its edges never meet the bus clock's
  initial
  begin
    #3;
    forever #80 video_clk = ~video_clk;
  end
  always @(posedge pixel_data_strobe) sr_cnt++;
  always @(posedge video_clk) vr_cnt++;
  video_sync_out video_sync_out_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .video_clk, .ext_sync, .palette_data,
    .pixel_data_strobe, .digital_pixel_port, .hsync_out, .vsync_out);
  pixel_sink pixel_sink_inst (.pixel_data_strobe, .digital_pixel_port, .sync_req, .ext_sync);
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic ran_out();
    check(1'b0, "wait ran out");
    complete_run();
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      if (++n > 2000) ran_out();
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Fresh reset mid-run, then a small raster: 16 pixels, 4 lines
  task automatic setup(input logic [31:0] ctrl);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `OFS_HTIM, 32'h0002_0010);
    apb(1'b1, `OFS_VTIM, 32'h0001_0004);
    apb(1'b1, `OFS_CTRL, ctrl);
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? hsync_out : vsync_out;
  endfunction
  task automatic wait_lvl(input int s, input logic lvl);
    int n;
    n = 0;
    while (pick(s) !== lvl)
    begin
      @(posedge pclk);
      if (++n > 20000) ran_out();
    end
  endtask
  // Length of the second whole high pulse, so a config change has settled
  task automatic width(input int s, output int n);
    repeat (2)
    begin
      wait_lvl(s, 1'b0);
      wait_lvl(s, 1'b1);
    end
    n = 0;
    while (pick(s) === 1'b1 && n < 20000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Strobe rises per link clock rise over 64 link periods
  task automatic rate(input int d);
    int s0, v0;
    s0 = sr_cnt;
    v0 = vr_cnt;
    repeat (512) @(posedge pclk);
    s0 = sr_cnt - s0;
    v0 = vr_cnt - v0;
    check(s0 * d >= v0 - d && s0 * d <= v0 + d, "strobe rate");
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_t[i])
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check(rd === rst_t[i] && er === 1'b0, "reset value");
    end
    apb(1'b1, 12'h040, 32'hFFFF_FFFF);
    apb(1'b0, 12'h040, 32'h0);
    check(rd === 32'h0 && er === 1'b1, "unmapped access");
    setup(32'h05);
    foreach (ext_t[i])
    begin
      apb(1'b1, `OFS_EXTCFG, ext_t[i]);
      width(sel_t[i], w);
      check(w == exp_t[i], "sync width");
    end
    // Composite vsync over one frame: 4 pixels on line 0, 12 on each other line
    apb(1'b1, `OFS_EXTCFG, 32'h0008_0000);
    width(1, w);
    w = 0;
    repeat (512)
    begin
      @(posedge pclk);
      if (vsync_out === 1'b1) w++;
    end
    check(w == 320, "composite vsync");
    // Fill the buffer until it refuses, then drain it through the port
    setup(32'h00);
    pixel_sink_inst.got_q.delete();
    for (int i = 1; i <= 32; i++) apb(1'b1, `OFS_DATA, 32'(i));
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rd[5:0] === 6'h20, "fifo full level");
    apb(1'b1, `OFS_CTRL, 32'h05);
    apb(1'b1, `OFS_DATA, 32'h21);
    rate(1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rd[5:0] === 6'h00, "fifo empty level");
    k = 0;
    while (k < 16 && pixel_sink_inst.got_q[k] !== 8'h01) k++;
    for (int i = 0; i < 34; i++)
      check(pixel_sink_inst.got_q[k + i] === ((i < 33) ? 8'(i + 1) : 8'h00), "byte");
    // Panel mode fed from the palette
    setup(32'h0F);
    palette_data <= 8'h5A;
    rate(4);
    check(pixel_sink_inst.got_q[$] === 8'h5A, "palette byte");
    // Raster running with the strobe switched off: no strobe edge at all
    setup(32'h01);
    w = sr_cnt;
    repeat (64) @(posedge pclk);
    check(sr_cnt == w && pixel_data_strobe === 1'b0, "strobe held off");
    // External sync pulled in while the line sits outside its sync pulse
    setup(32'h15);
    wait_lvl(0, 1'b1);
    wait_lvl(0, 1'b0);
    repeat (10) @(posedge pclk);
    sync_req <= 1'b1;
    k = 0;
    while (hsync_out !== 1'b1 && k < 40)
    begin
      @(posedge pclk);
      k++;
    end
    check(k <= 16, "hsync realign");
    sync_req <= 1'b0;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire

// ---- dv/video_sync_out_props.sv ----
// Concurrent checks on the pins of the video sync and pixel output block
`include "video_sync_defines.vh"
`default_nettype none
module video_sync_out_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        video_clk,
  input wire logic        pixel_data_strobe,
  input wire logic [7:0]  digital_pixel_port,
  input wire logic        hsync_out
);
  logic [6:0] vclk_sh;  // Recent samples of the link clock
  logic [3:0] wr_sh;    // Recent register writes, which may retime the syncs
  logic       vrise;    // A link clock rise lies two to six samples back
  logic       cause;    // Something allowed to move the sync outputs
  // History kept so that checks can look back across the synchroniser delay
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vclk_sh <= 7'h00;
      wr_sh   <= 4'h0;
    end
    else
    begin
      vclk_sh <= {vclk_sh[5:0], video_clk};
      wr_sh   <= {wr_sh[2:0], psel & penable & pwrite};
    end
  end
  assign vrise = |(vclk_sh[5:1] & ~vclk_sh[6:2]);
  assign cause = vrise | (|wr_sh);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Strobe phases last at least half a link period
  sequence s_hold_hi;
    pixel_data_strobe [*4];
  endsequence
  sequence s_hold_lo;
    !pixel_data_strobe [*4];
  endsequence
  property p_rst_idle;
    $rose(presetn) |-> !pixel_data_strobe && !hsync_out && digital_pixel_port == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
  property p_port_hold;
    $changed(digital_pixel_port) |-> !pixel_data_strobe;
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port moved under strobe");
  property p_stb_rise;
    $rose(pixel_data_strobe) |-> vrise;
  endproperty
  a_stb_rise: assert property (p_stb_rise) else $error("strobe rose off a tick");
  property p_stb_high;
    $rose(pixel_data_strobe) |-> s_hold_hi;
  endproperty
  a_stb_high: assert property (p_stb_high) else $error("strobe high too short");
  property p_stb_low;
    $fell(pixel_data_strobe) |-> s_hold_lo;
  endproperty
  a_stb_low: assert property (p_stb_low) else $error("strobe low too short");
  property p_hs_tick;
    $changed(hsync_out) |-> cause;
  endproperty
  a_hs_tick: assert property (p_hs_tick) else $error("hsync moved off a tick");
  property p_ready;
    psel && !(pwrite && paddr == `OFS_DATA) |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("unexpected wait state");
  property p_slverr;
    psel && penable |-> pslverr == (paddr > `OFS_STATUS || paddr[1:0] != 2'h0);
  endproperty
  a_slverr: assert property (p_slverr) else $error("wrong error response");
endmodule // video_sync_out_props
bind video_sync_out video_sync_out_props video_sync_out_props_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .video_clk, .pixel_data_strobe,
  .digital_pixel_port, .hsync_out);
`default_nettype wire

// ---- rtl/video_sync_defines.vh ----
// Constants for the video sync and digital pixel output block
`ifndef VIDEO_SYNC_DEFINES_VH
`define VIDEO_SYNC_DEFINES_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_EXTCFG    12'h004
`define OFS_HTIM      12'h008
`define OFS_VTIM      12'h00C
`define OFS_DATA      12'h010
`define OFS_STATUS    12'h014
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_EN       0
`define CTRL_LCD      1
`define CTRL_STB_EN   2
`define CTRL_PAL_SRC  3
`define CTRL_XSYNC_EN 4
`define CTRL_W        5
// ----------------------------------------------------------------
// External configuration fields (sync selection)
// ----------------------------------------------------------------
`define EXT_HPOL      16
`define EXT_HCOMP     17
`define EXT_VPOL      18
`define EXT_VCOMP     19
// ----------------------------------------------------------------
// Timing register fields
// ----------------------------------------------------------------
`define TOT_LSB       0
`define TOT_MSB       11
`define SW_LSB        16
`define SW_MSB        23
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CTRL      5'h00
`define RST_EXT       4'h0
`define RST_HTOT      12'h320
`define RST_HSW       8'h30
`define RST_VTOT      12'h20D
`define RST_VSW       8'h02
// ----------------------------------------------------------------
// Pixel divider for panel mode
// ----------------------------------------------------------------
`define LCD_STB_HI    2'h0
`define LCD_STB_LO    2'h2
`endif

// ---- rtl/video_sync_out.v ----
// Video sync generator and digital pixel port with APB registers and FIFO
// Functional notes
// - Normal mode: data strobe at pixel rate
// - Panel mode: data strobe at quarter rate
// - Each strobe cycle marks valid port data
// - Port carries colour data or palette data
// - Panel data leaves through same port
// - Bits 17:16 select plain or composite hsync
// - Hsync polarity selectable high or low
// - Hsync width programmed in two-pixel steps
// - External sync input realigns video timing
// - Video timing runs on pclk, stepped by sampled video clock edges
// - Bits 19:18 select vsync or composite
// - Vsync width programmed in whole lines
`include "video_sync_defines.vh"
`default_nettype none

// ----------------------------------------------------------------
// Pixel FIFO
// ----------------------------------------------------------------
module pixel_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Word storage
  reg [AW-1:0]    wr_q;              // Write index
  reg [AW-1:0]    rd_q;              // Read index
  reg [AW:0]      cnt_q;             // Words held
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];
  assign level     = cnt_q;

  // Storage takes no reset; only the pointers and fill count need a defined state
  always @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointer and fill count update
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
      begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop)
      begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end
      else if (pop & ~push)
      begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // pixel_fifo

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module video_sync_out (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        video_clk,
  input  wire        ext_sync,
  input  wire [7:0]  palette_data,
  output reg         pixel_data_strobe,
  output reg  [7:0]  digital_pixel_port,
  output reg         hsync_out,
  output reg         vsync_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next counter value with wrap at the programmed total
  function [11:0] cnt_next;
    input [11:0] c;
    input [11:0] t;
    begin
      cnt_next = (c >= t - 12'h001) ? 12'h000 : c + 12'h001;
    end
  endfunction

  // Select plain or composite sync and apply polarity
  function sync_sel;
    input plain;
    input comp;
    input use_comp;
    input act_low;
    begin
      sync_sel = (use_comp ? comp : plain) ^ act_low;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg [`CTRL_W-1:0] ctrl_q;     // Mode and enable bits
  reg [3:0]         ext_q;      // Sync selection bits 19:16
  reg [11:0]        htot_q;     // Pixels per line
  reg [7:0]         hsw_q;      // Hsync width, two-pixel units
  reg [11:0]        vtot_q;     // Lines per frame
  reg [7:0]         vsw_q;      // Vsync width in lines
  reg [11:0]        hcnt_q;     // Pixel position in line
  reg [11:0]        vcnt_q;     // Line position in frame
  reg [1:0]         div_q;      // Quarter-rate divider
  reg [2:0]         vclk_s_q;   // Video clock sampler chain
  reg [2:0]         xs_s_q;     // External sync sampler chain
  reg [7:0]         pal_s1_q;   // Palette data first stage
  reg [7:0]         pal_s2_q;   // Palette data second stage

  wire        acc;
  wire        wr;
  wire        setup;
  wire        data_hit;
  wire        fifo_in_ready;
  wire        fifo_valid;
  wire [7:0]  fifo_data;
  wire [5:0]  fifo_level;
  wire        pix_rise;
  wire        pix_fall;
  wire        xs_rise;
  wire        load;
  wire        pop;
  wire        h_act;
  wire        v_act;
  wire        en;
  wire        lcd;

  assign en    = ctrl_q[`CTRL_EN];
  assign lcd   = ctrl_q[`CTRL_LCD];
  assign setup = psel & ~penable;
  assign acc   = psel & penable;
  assign wr    = acc & pwrite;
  assign data_hit = (paddr == `OFS_DATA);

  // Writes to the data register stall while the FIFO is full
  assign pready = ~(pwrite & data_hit) | fifo_in_ready;

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  // Two stages before any logic looks; the third only feeds edge finding
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vclk_s_q <= 3'h0;
      xs_s_q   <= 3'h0;
      pal_s1_q <= 8'h00;
      pal_s2_q <= 8'h00;
    end
    else
    begin
      vclk_s_q <= {vclk_s_q[1:0], video_clk};
      xs_s_q   <= {xs_s_q[1:0], ext_sync};
      pal_s1_q <= palette_data;
      pal_s2_q <= pal_s1_q;
    end
  end

  // Pixel edges come from the video clock, never from the bus clock
  assign pix_rise = vclk_s_q[1] & ~vclk_s_q[2];
  assign pix_fall = ~vclk_s_q[1] & vclk_s_q[2];
  assign xs_rise  = xs_s_q[1] & ~xs_s_q[2];

  // ----------------------------------------------------------------
  // APB register writes
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `RST_CTRL;
      ext_q  <= `RST_EXT;
      htot_q <= `RST_HTOT;
      hsw_q  <= `RST_HSW;
      vtot_q <= `RST_VTOT;
      vsw_q  <= `RST_VSW;
    end
    else if (wr)
    begin
      case (paddr)
        `OFS_CTRL:
        begin
          ctrl_q <= pwdata[`CTRL_W-1:0];
        end
        `OFS_EXTCFG:
        begin
          ext_q <= pwdata[`EXT_VCOMP:`EXT_HPOL];
        end
        `OFS_HTIM:
        begin
          htot_q <= pwdata[`TOT_MSB:`TOT_LSB];
          hsw_q  <= pwdata[`SW_MSB:`SW_LSB];
        end
        `OFS_VTIM:
        begin
          vtot_q <= pwdata[`TOT_MSB:`TOT_LSB];
          vsw_q  <= pwdata[`SW_MSB:`SW_LSB];
        end
        default:
        begin
          ctrl_q <= ctrl_q; // Data and status writes leave config alone
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read data and error, captured in the setup cycle
  // ----------------------------------------------------------------
  // Registering here keeps prdata off a long decode path
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= 1'b0;
      case (paddr)
        `OFS_CTRL:   prdata <= {27'h0000000, ctrl_q};
        `OFS_EXTCFG: prdata <= {12'h000, ext_q, 16'h0000};
        `OFS_HTIM:   prdata <= {8'h00, hsw_q, 4'h0, htot_q};
        `OFS_VTIM:   prdata <= {8'h00, vsw_q, 4'h0, vtot_q};
        `OFS_DATA:   prdata <= 32'h0000_0000;
        `OFS_STATUS: prdata <= {4'h0, vcnt_q, 10'h000, fifo_level};
        default:
        begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1; // Unmapped address
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pixel FIFO between bus writes and the port
  // ----------------------------------------------------------------
  pixel_fifo #(
    .WIDTH (8),
    .DEPTH (32),
    .AW    (5)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (wr & data_hit),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  // ----------------------------------------------------------------
  // Raster counters
  // ----------------------------------------------------------------
  // External sync restarts the frame so two systems stay locked
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hcnt_q <= 12'h000;
      vcnt_q <= 12'h000;
    end
    else if (!en)
    begin
      hcnt_q <= 12'h000;
      vcnt_q <= 12'h000;
    end
    else if (ctrl_q[`CTRL_XSYNC_EN] & xs_rise)
    begin
      hcnt_q <= 12'h000;
      vcnt_q <= 12'h000;
    end
    else if (pix_rise)
    begin
      hcnt_q <= cnt_next(hcnt_q, htot_q);
      if (cnt_next(hcnt_q, htot_q) == 12'h000)
      begin
        vcnt_q <= cnt_next(vcnt_q, vtot_q);
      end
    end
  end

  // Active-high internal syncs
  assign h_act = (hcnt_q < {3'h0, hsw_q, 1'b0});
  assign v_act = (vcnt_q < {4'h0, vsw_q});

  // ----------------------------------------------------------------
  // Sync outputs
  // ----------------------------------------------------------------
  // While enabled, updated only at pixel edges so they line up with the strobe
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
    end
    else if (!en)
    begin
      hsync_out <= ext_q[0]; // Inactive level of chosen polarity for plain hsync
      vsync_out <= ext_q[2];
    end
    else if (pix_rise)
    begin
      // Composite hsync NOR comes out active low and composite vsync is an XNOR, before polarity is applied
      hsync_out <= sync_sel(h_act, ~(h_act | v_act),
                            ext_q[1], ext_q[0]);
      vsync_out <= sync_sel(v_act, ~(h_act ^ v_act),
                            ext_q[3], ext_q[2]);
    end
  end

  // ----------------------------------------------------------------
  // Data strobe and pixel port
  // ----------------------------------------------------------------
  // Data changes as the strobe falls, so it is stable at each rising edge
  assign load = en & (lcd ? (pix_rise & (div_q == `LCD_STB_LO)) : pix_fall);
  assign pop  = load & ~ctrl_q[`CTRL_PAL_SRC];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q              <= 2'h0;
      pixel_data_strobe  <= 1'b0;
      digital_pixel_port <= 8'h00;
    end
    else if (!en)
    begin
      div_q              <= 2'h0;
      pixel_data_strobe  <= 1'b0;
      digital_pixel_port <= 8'h00;
    end
    else
    begin
      if (pix_rise)
      begin
        div_q <= div_q + 2'h1;
      end
      // Strobe high phase
      if (ctrl_q[`CTRL_STB_EN] & pix_rise & (~lcd | (div_q == `LCD_STB_HI)))
      begin
        pixel_data_strobe <= 1'b1;
      end
      else if (load | ~ctrl_q[`CTRL_STB_EN])
      begin
        pixel_data_strobe <= 1'b0;
      end
      // New byte each strobe period; an empty FIFO shows zero
      if (load)
      begin
        if (ctrl_q[`CTRL_PAL_SRC])
        begin
          digital_pixel_port <= pal_s2_q;
        end
        else
        begin
          digital_pixel_port <= fifo_valid ? fifo_data : 8'h00;
        end
      end
    end
  end
endmodule // video_sync_out
`default_nettype wire
